// ### hdl/tef_event_flags.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Capture event sets capture_event_flag at bit 5.
// - In capture-as-top mode, counter reaching top also sets capture flag.
// - Capture interrupt requested when flag, its enable and global flag set.
// - Capture flag stays set until software writes one; hardware never clears.
// - Compare matches A, B, C set flags at bits 1, 2, 3.
// - Each compare interrupt requested when flag, enable and global flag set.
// - Compare flags clear only on write of one; zero leaves them.
// - Overflow sets wrap_flag bit 0; interrupt when enable and global set.
// - Overflow flag persists until software writes one to it.
// - Enable register: wrap bit 0, match A 1, B 2, C 3.
module tef_event_flags (
    input  wire logic        aclk,            // System clock
    input  wire logic        aresetn,         // Sync reset, active low
    input  wire logic        capture_event,   // Input capture pulse
    input  wire logic        capture_is_top,  // Capture register serves as top
    input  wire logic        count_at_top,    // Counter equals capture value
    input  wire logic        match_a_event,   // Count equals compare A
    input  wire logic        match_b_event,   // Count equals compare B
    input  wire logic        match_c_event,   // Count equals compare C
    input  wire logic        wrap_event,      // Counter overflow pulse
    output logic             capture_irq,     // Capture interrupt request
    output logic             match_a_irq,     // Compare A interrupt request
    output logic             match_b_irq,     // Compare B interrupt request
    output logic             match_c_irq,     // Compare C interrupt request
    output logic             wrap_irq,        // Overflow interrupt request
    output logic             irq,             // Masked summary interrupt
    input  wire logic [3:0]  s_axi_awaddr,    // Write address
    input  wire logic        s_axi_awvalid,   // Write address valid
    output logic             s_axi_awready,   // Write address ready
    input  wire logic [31:0] s_axi_wdata,     // Write data
    input  wire logic [3:0]  s_axi_wstrb,     // Write strobes
    input  wire logic        s_axi_wvalid,    // Write data valid
    output logic             s_axi_wready,    // Write data ready
    output logic [1:0]       s_axi_bresp,     // Write response
    output logic             s_axi_bvalid,    // Write response valid
    input  wire logic        s_axi_bready,    // Write response ready
    input  wire logic [3:0]  s_axi_araddr,    // Read address
    input  wire logic        s_axi_arvalid,   // Read address valid
    output logic             s_axi_arready,   // Read address ready
    output logic [31:0]      s_axi_rdata,     // Read data
    output logic [1:0]       s_axi_rresp,     // Read response
    output logic             s_axi_rvalid,    // Read data valid
    input  wire logic        s_axi_rready     // Read data ready
);

    // Timing seen from the bus: a write commits one cycle after both halves
    // are held and answers on that same edge; a read answers one cycle
    // after its address is taken. An event shows in the flag one cycle later
    // and in its request line one cycle after that.
    // The summary line uses the mask alone, so it can signal even while the
    // global flag is off; the per-source lines need enable and global flag.

    // Register state
    logic [7:0]  flags_q, flags_d;
    logic [7:0]  enable_q, enable_d;
    logic [7:0]  mask_q, mask_d;
    logic        gie_q, gie_d;
    logic [4:0]  irqs_d;
    logic        irq_d;
    // Write channel state
    logic        aw_held_q, aw_held_d;
    logic        w_held_q, w_held_d;
    logic [3:0]  awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic        wstrb0_q, wstrb0_d;
    logic        awready_d;
    logic        wready_d;
    logic        bvalid_d;
    logic [1:0]  bresp_d;
    // Read channel state
    logic        arready_d;
    logic        rvalid_d;
    logic [1:0]  rresp_d;
    logic [31:0] rdata_d;
    // Decoded write strobe and flag update vectors
    logic        do_write;
    logic [7:0]  set_vec;
    logic [7:0]  clr_vec;

    // Decode whether an address maps to a register
    function automatic logic addr_mapped(input logic [3:0] a);
        if (a == tef_pkg::ADDR_FLAGS) begin
            return 1'b1;
        end else if (a == tef_pkg::ADDR_ENABLE) begin
            return 1'b1;
        end else if (a == tef_pkg::ADDR_MASK) begin
            return 1'b1;
        end else if (a == tef_pkg::ADDR_CTRL) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction

    // One request line: its flag, its enable and the global flag together
    // Shared by all five sources so they cannot drift apart in gating
    function automatic logic gated_request(input logic flag, input logic en, input logic glob);
        return flag & en & glob;
    endfunction

    // Write channel capture; address and data may arrive in either order
    // A new address may be held while a response waits; it commits afterwards
    always_comb begin
        aw_held_d = aw_held_q;
        w_held_d  = w_held_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wstrb0_d  = wstrb0_q;
        bvalid_d  = s_axi_bvalid;
        bresp_d   = s_axi_bresp;
        do_write  = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_d = 1'b1;
            awaddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb0_d = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        // Commit once both halves are held and no response is pending
        if (aw_held_q && w_held_q && !s_axi_bvalid) begin
            do_write  = 1'b1;
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = addr_mapped(awaddr_q) ? tef_pkg::RESP_OKAY : tef_pkg::RESP_SLVERR;
        end
        // Ready drops after a handshake so each channel takes one item
        awready_d = !aw_held_d && !(s_axi_awvalid && s_axi_awready);
        wready_d  = !w_held_d && !(s_axi_wvalid && s_axi_wready);
    end

    // Hardware events; set wins over a same-cycle software clear
    // so an event landing on the clear cycle is never lost
    always_comb begin
        set_vec = 8'h00;
        set_vec[tef_pkg::BIT_CAPTURE] = capture_event
                                      | (capture_is_top & count_at_top);
        set_vec[tef_pkg::BIT_MATCH_A] = match_a_event;
        set_vec[tef_pkg::BIT_MATCH_B] = match_b_event;
        set_vec[tef_pkg::BIT_MATCH_C] = match_c_event;
        set_vec[tef_pkg::BIT_WRAP]    = wrap_event;
        clr_vec = 8'h00;
        if (do_write && wstrb0_q && awaddr_q == tef_pkg::ADDR_FLAGS) begin
            clr_vec = wdata_q[7:0] & tef_pkg::FLAG_MASK;
        end
        // Only software write-one clears; hardware never clears
        flags_d = ((flags_q & ~clr_vec) | set_vec) & tef_pkg::FLAG_MASK;
    end

    // Control registers; only byte lane 0 carries data
    // A write with lane 0 off is answered OKAY but changes nothing
    // Enable and mask keep the flag layout, so unused bits stay zero
    always_comb begin
        enable_d = enable_q;
        mask_d   = mask_q;
        gie_d    = gie_q;
        if (do_write && wstrb0_q) begin
            if (awaddr_q == tef_pkg::ADDR_ENABLE) begin
                enable_d = wdata_q[7:0] & tef_pkg::FLAG_MASK;
            end else if (awaddr_q == tef_pkg::ADDR_MASK) begin
                mask_d = wdata_q[7:0] & tef_pkg::FLAG_MASK;
            end else if (awaddr_q == tef_pkg::ADDR_CTRL) begin
                gie_d = wdata_q[tef_pkg::BIT_GIE];
            end
        end
    end

    // Per-source requests gated by enable and global flag
    always_comb begin
        // Levels: each falls once software clears its flag or enable
        irqs_d[0] = gated_request(flags_q[tef_pkg::BIT_WRAP], enable_q[tef_pkg::BIT_WRAP], gie_q);
        irqs_d[1] = gated_request(flags_q[tef_pkg::BIT_MATCH_A], enable_q[tef_pkg::BIT_MATCH_A], gie_q);
        irqs_d[2] = gated_request(flags_q[tef_pkg::BIT_MATCH_B], enable_q[tef_pkg::BIT_MATCH_B], gie_q);
        irqs_d[3] = gated_request(flags_q[tef_pkg::BIT_MATCH_C], enable_q[tef_pkg::BIT_MATCH_C], gie_q);
        irqs_d[4] = gated_request(flags_q[tef_pkg::BIT_CAPTURE], enable_q[tef_pkg::BIT_CAPTURE], gie_q);
        irq_d     = |(flags_q & mask_q);
    end

    // Read channel; one read at a time, answer one cycle after address
    // Unmapped offsets answer with an error and zero data
    always_comb begin
        rvalid_d = s_axi_rvalid;
        rresp_d  = s_axi_rresp;
        rdata_d  = s_axi_rdata;
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d  = tef_pkg::RESP_OKAY;
            rdata_d  = 32'h0000_0000;
            if (s_axi_araddr == tef_pkg::ADDR_FLAGS) begin
                rdata_d[7:0] = flags_q;
            end else if (s_axi_araddr == tef_pkg::ADDR_ENABLE) begin
                rdata_d[7:0] = enable_q;
            end else if (s_axi_araddr == tef_pkg::ADDR_MASK) begin
                rdata_d[7:0] = mask_q;
            end else if (s_axi_araddr == tef_pkg::ADDR_CTRL) begin
                rdata_d[tef_pkg::BIT_GIE] = gie_q;
            end else begin
                rresp_d = tef_pkg::RESP_SLVERR;
            end
        end
        // No new address is taken while an answer waits for rready
        arready_d = !rvalid_d && !(s_axi_arvalid && s_axi_arready);
    end

    // Flag register; sets and clears are merged in the next-value logic
    // so this process only holds the result
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_q <= tef_pkg::FLAGS_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    // Enable, mask and global interrupt flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_q <= tef_pkg::ENABLE_RESET;
            mask_q   <= tef_pkg::MASK_RESET;
            gie_q    <= 1'b0;
        end else begin
            enable_q <= enable_d;
            mask_q   <= mask_d;
            gie_q    <= gie_d;
        end
    end

    // Write channel; readys stay low in reset so nothing is taken early
    // Held address and data wait here until the commit cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            awaddr_q      <= 4'h0;
            wdata_q       <= 32'h0000_0000;
            wstrb0_q      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end else begin
            aw_held_q     <= aw_held_d;
            w_held_q      <= w_held_d;
            awaddr_q      <= awaddr_d;
            wdata_q       <= wdata_d;
            wstrb0_q      <= wstrb0_d;
            s_axi_awready <= awready_d;
            s_axi_wready  <= wready_d;
            s_axi_bvalid  <= bvalid_d;
            s_axi_bresp   <= bresp_d;
        end
    end

    // Read channel; data and response stand with rvalid
    // until the master takes them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= 2'h0;
            s_axi_rdata   <= 32'h0000_0000;
        end else begin
            s_axi_arready <= arready_d;
            s_axi_rvalid  <= rvalid_d;
            s_axi_rresp   <= rresp_d;
            s_axi_rdata   <= rdata_d;
        end
    end

    // Interrupt outputs come from flip-flops; this costs one cycle of
    // latency but keeps the request lines free of glitches
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wrap_irq    <= 1'b0;
            match_a_irq <= 1'b0;
            match_b_irq <= 1'b0;
            match_c_irq <= 1'b0;
            capture_irq <= 1'b0;
            irq         <= 1'b0;
        end else begin
            wrap_irq    <= irqs_d[0];
            match_a_irq <= irqs_d[1];
            match_b_irq <= irqs_d[2];
            match_c_irq <= irqs_d[3];
            capture_irq <= irqs_d[4];
            irq         <= irq_d;
        end
    end

endmodule
`default_nettype wire

// ### hdl/tef_pkg.sv
`default_nettype none
package tef_pkg;
    // Register byte offsets
    localparam logic [3:0] ADDR_FLAGS  = 4'h0;
    localparam logic [3:0] ADDR_ENABLE = 4'h4;
    localparam logic [3:0] ADDR_MASK   = 4'h8;
    localparam logic [3:0] ADDR_CTRL   = 4'hc;
    // Field positions in flag, enable and control registers
    localparam int BIT_WRAP    = 0;
    localparam int BIT_MATCH_A = 1;
    localparam int BIT_MATCH_B = 2;
    localparam int BIT_MATCH_C = 3;
    localparam int BIT_CAPTURE = 5;
    localparam int BIT_GIE     = 0;
    // Writable and implemented flag bits
    localparam logic [7:0] FLAG_MASK   = 8'h2f;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET  = 8'h00;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ### verif/tef_event_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tef_event_flags_tb;
    logic        aclk = 0, aresetn = 0, cap_top = 0; // Clock, reset, top mode
    logic [5:0]  ev = 0;                             // Wrap, a, b, c, capture, at top
    logic        awv = 0, wv = 0, brdy = 0;          // Write requests
    logic        arv = 0, rrdy = 0;                  // Read requests
    logic [3:0]  awa = 0, ara = 0;                   // Addresses
    logic [31:0] wd = 0;                             // Write data
    logic [3:0]  ws = 4'hf;                          // Write strobes
    wire  [4:0]  irqs;                               // Requests, event order
    wire         irq, awr, wrr, bv, arr, rv;         // Summary and bus answers
    wire  [1:0]  bresp, rresp;                       // Responses
    wire  [31:0] rdq;                                // Read data
    int          failures = 0, check_count = 0;      // Report counters
    always #2.5 aclk = ~aclk;
    tef_event_flags dut_u (.aclk, .aresetn, .capture_event(ev[4]), .capture_is_top(cap_top),
        .count_at_top(ev[5]), .match_a_event(ev[1]), .match_b_event(ev[2]), .match_c_event(ev[3]),
        .wrap_event(ev[0]), .capture_irq(irqs[4]), .match_a_irq(irqs[1]), .match_b_irq(irqs[2]),
        .match_c_irq(irqs[3]), .wrap_irq(irqs[0]), .irq, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wrr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdq),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy));
    // Four-state compare so an unknown never passes
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // One bus access; each valid drops once taken, the answer is awaited under a bound
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        awa <= a;
        ara <= a;
        wd <= {24'h0, d};
        awv <= w;
        wv <= w;
        brdy <= w;
        arv <= !w;
        rrdy <= !w;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wrr) wv <= 1'b0;
            if (arr) arv <= 1'b0;
            if (bv || rv) break;
        end
        if (n == 40) begin
            failures++;
            close_out();
        end
        chk({30'h0, w ? bresp : rresp}, {30'h0, er});
        if (!w) chk(rdq, {24'h0, d});
        brdy <= 1'b0;
        rrdy <= 1'b0;
        @(posedge aclk);
    endtask
    // One-cycle event pulse, then room for the registered request
    task automatic pulse(input logic [5:0] v);
        ev <= v;
        @(posedge aclk);
        ev <= 6'h0;
        repeat (3) @(posedge aclk);
    endtask
    // Each source alone: flag, request, zeros ignored, a one clears
    task automatic t_each;
        int b;
        bus(0, 4'h4, 8'h00, 2'h0);
        bus(1, 4'hc, 8'h01, 2'h0);
        bus(1, 4'h4, 8'h2f, 2'h0);
        for (int i = 0; i < 5; i++) begin
            b = (i == 4) ? tef_pkg::BIT_CAPTURE : i;
            pulse(6'(1 << i));
            bus(0, 4'h0, 8'(1 << b), 2'h0);
            chk({27'h0, irqs}, 32'(1 << i));
            bus(1, 4'h0, ~8'(1 << b), 2'h0);
            bus(0, 4'h0, 8'(1 << b), 2'h0);
            bus(1, 4'h0, 8'(1 << b), 2'h0);
            bus(0, 4'h0, 8'h00, 2'h0);
            chk({27'h0, irqs}, 32'h0);
        end
    endtask
    // Global flag and enables gate requests; mask gates the summary line
    task automatic t_gate;
        bus(1, 4'hc, 8'h00, 2'h0);
        pulse(6'h1f);
        chk({27'h0, irqs}, 32'h0);
        bus(0, 4'h0, 8'h2f, 2'h0);
        bus(1, 4'hc, 8'h01, 2'h0);
        chk({27'h0, irqs}, 32'h1f);
        bus(1, 4'h4, 8'h0a, 2'h0);
        chk({27'h0, irqs}, 32'h0a);
        chk({31'h0, irq}, 32'h0);
        bus(1, 4'h8, 8'h20, 2'h0);
        chk({31'h0, irq}, 32'h1);
        bus(1, 4'h0, 8'hdf, 2'h0);
        bus(0, 4'h0, 8'h20, 2'h0);
        bus(1, 4'h0, 8'h20, 2'h0);
        chk({31'h0, irq}, 32'h0);
    endtask
    // Reaching top sets the capture flag only in capture-as-top mode; bad offset refused
    task automatic t_top;
        pulse(6'h20);
        bus(0, 4'h0, 8'h00, 2'h0);
        cap_top <= 1'b1;
        pulse(6'h20);
        bus(0, 4'h0, 8'h20, 2'h0);
        bus(1, 4'h2, 8'hff, tef_pkg::RESP_SLVERR);
        bus(0, 4'h2, 8'h00, tef_pkg::RESP_SLVERR);
    endtask
    // A capture on the clearing cycle keeps the flag; lane 0 off changes nothing
    task automatic t_race;
        fork
            bus(1, 4'h0, 8'h20, 2'h0);
            begin
                @(posedge aclk);
                ev <= 6'h10;
                @(posedge aclk);
                ev <= 6'h00;
            end
        join
        bus(0, 4'h0, 8'h20, 2'h0);
        bus(1, 4'h0, 8'h20, 2'h0);
        bus(0, 4'h0, 8'h00, 2'h0);
        ws <= 4'h0;
        bus(1, 4'h4, 8'hff, 2'h0);
        ws <= 4'hf;
        bus(0, 4'h4, 8'h0a, 2'h0);
    endtask
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_each();
        t_gate();
        t_top();
        t_race();
        close_out();
    end
endmodule
`default_nettype wire

// ### verif/tef_flags_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the event flag block
module tef_flags_chk (
    input wire logic        aclk,           // Clock
    input wire logic        aresetn,        // Sync reset, active low
    input wire logic        capture_event,  // Capture pulse
    input wire logic        capture_is_top, // Capture register is top
    input wire logic        count_at_top,   // Counter at top
    input wire logic        wrap_event,     // Overflow pulse
    input wire logic        capture_irq,    // Capture request
    input wire logic        wrap_irq,       // Overflow request
    input wire logic        match_a_irq,    // Compare A request
    input wire logic        match_b_irq,    // Compare B request
    input wire logic        match_c_irq,    // Compare C request
    input wire logic        s_axi_bvalid,   // Write answer
    input wire logic        s_axi_arvalid,  // Read address valid
    input wire logic        s_axi_arready,  // Read address ready
    input wire logic        s_axi_rvalid,   // Read answer
    input wire logic [3:0]  s_axi_araddr,   // Read address
    input wire logic [31:0] s_axi_rdata     // Read data
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Only a write answer may drop a request, since hardware never clears flags
    property p_cap_hold; capture_irq && !s_axi_bvalid |=> capture_irq; endproperty
    a_cap_hold: assert property (p_cap_hold) else $error("capture dropped");
    property p_a_hold; match_a_irq && !s_axi_bvalid |=> match_a_irq; endproperty
    a_a_hold: assert property (p_a_hold) else $error("match a dropped");
    property p_b_hold; match_b_irq && !s_axi_bvalid |=> match_b_irq; endproperty
    a_b_hold: assert property (p_b_hold) else $error("match b dropped");
    property p_c_hold; match_c_irq && !s_axi_bvalid |=> match_c_irq; endproperty
    a_c_hold: assert property (p_c_hold) else $error("match c dropped");
    property p_w_hold; wrap_irq && !s_axi_bvalid |=> wrap_irq; endproperty
    a_w_hold: assert property (p_w_hold) else $error("wrap dropped");
    // A request rises two cycles after its event, or after a register write
    property p_cap_cause;
        $rose(capture_irq) |-> $past(capture_event, 2) || $past(s_axi_bvalid) ||
            ($past(count_at_top, 2) && $past(capture_is_top, 2));
    endproperty
    a_cap_cause: assert property (p_cap_cause) else $error("capture uncaused");
    property p_w_cause; $rose(wrap_irq) |-> $past(wrap_event, 2) || $past(s_axi_bvalid); endproperty
    a_w_cause: assert property (p_w_cause) else $error("wrap uncaused");
    // Spare flag bits read back as zero
    property p_rsvd;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == tef_pkg::ADDR_FLAGS |->
            ##[1:2] (s_axi_rvalid && s_axi_rdata[7:6] == 2'h0 && !s_axi_rdata[4]);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("spare bits set");
    c_cap: cover property (capture_irq);
    c_wrap: cover property (wrap_irq && match_c_irq);
    c_read: cover property (s_axi_rvalid && s_axi_rdata[5]);
endmodule
bind tef_event_flags tef_flags_chk chk_u (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .capture_event  (capture_event),
    .capture_is_top (capture_is_top),
    .count_at_top   (count_at_top),
    .wrap_event     (wrap_event),
    .capture_irq    (capture_irq),
    .wrap_irq       (wrap_irq),
    .match_a_irq    (match_a_irq),
    .match_b_irq    (match_b_irq),
    .match_c_irq    (match_c_irq),
    .s_axi_bvalid   (s_axi_bvalid),
    .s_axi_arvalid  (s_axi_arvalid),
    .s_axi_arready  (s_axi_arready),
    .s_axi_rvalid   (s_axi_rvalid),
    .s_axi_araddr   (s_axi_araddr),
    .s_axi_rdata    (s_axi_rdata)
);
`default_nettype wire
